// ==== rtl/pfp_core.sv ====
// Fault detection, turn-off sequencing and group line propagation.
// Assumes analog comparators give millivolt samples on core_clk.
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module pfp_core
  import pfp_pkg::*;
#(
  parameter int unsigned RETRY = RETRY_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurements and on command
  input  wire pfp_meas_t   meas,
  input  wire logic        on_cmd,
  // Group fault line, open drain
  input  wire logic        fault_line_in,
  output logic             fault_line_out,
  output logic             fault_line_oe,
  // Power stage and interrupt
  output var pfp_drive_t   drive,
  output logic             irq
);
  typedef struct packed {
    pfp_state_t  st;
    logic        en;          // Converter enable
    logic        latching;
    logic        track_en;
    logic        prop_en;
    logic [7:0]  ov_pct;
    logic [15:0] delay;
    logic [15:0] dly_cnt;
    logic [5:0]  flags;       // 0 = tripped
    logic [5:0]  irq_st;
    logic [5:0]  mask;
    logic        err_off;     // Current shutdown is an error
    logic        own_fault;   // Fault line pulled by us
    logic        on_prev;
    logic        ls_hold;
    logic        line_s1;
    logic        line_s2;
    logic        retry_ok;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    pfp_drive_t  drive;
    logic        line_oe;
    logic        irq;
  } pfp_s_t;
  pfp_s_t s_reg, s_next;

  logic        tmr_start;
  logic        tmr_done;
  logic [23:0] ov_prod;
  logic [15:0] ov_thr;
  logic        armed;
  logic        ov_hit;
  logic        oc_hit;
  logic        tr_hit;
  logic [15:0] tr_diff;
  logic        line_low;
  logic [5:0]  ev;
  logic        acc;
  logic        rd_flags;

  // Threshold in millivolts, clamped to the 1.0V floor
  function automatic logic [15:0] ov_threshold(input logic [15:0] sp,
                                               input logic [7:0] pct);
    logic [23:0] p;
    logic [15:0] t;
    p = sp * pct / 24'd100;
    t = p[15:0];
    if (t < OV_FLOOR_MV) t = OV_FLOOR_MV;
    return t;
  endfunction

  // Software percentage limited to its legal window
  function automatic logic [7:0] pct_clamp(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (r < OV_PCT_MIN) r = OV_PCT_MIN;
    if (r > OV_PCT_MAX) r = OV_PCT_MAX;
    return r;
  endfunction

  // Detection terms
  always_comb begin
    ov_prod  = '0;
    ov_thr   = ov_threshold(meas.setpoint_mv, s_reg.ov_pct);
    armed    = meas.vout_mv > meas.prebias_mv;
    ov_hit   = armed && (meas.vout_mv > ov_thr);
    oc_hit   = armed && meas.oc_trip;
    tr_diff  = (meas.vout_mv > meas.ramp_ref_mv) ?
               meas.vout_mv - meas.ramp_ref_mv :
               meas.ramp_ref_mv - meas.vout_mv;
    tr_hit   = s_reg.track_en && (s_reg.st == PFP_RAMP) &&
               (tr_diff > TRACK_MV);
    line_low = !s_reg.line_s2 && !s_reg.own_fault;
    ev       = '0;
    ev[F_OV] = ov_hit;
    ev[F_OC] = oc_hit;
    ev[F_UV] = meas.uv_trip && (s_reg.st == PFP_ON);
    ev[F_OT] = meas.ot_trip;
    ev[F_TR] = tr_hit;
    ev[F_EXT] = line_low && s_reg.en;
    acc      = psel && penable && !s_reg.pready;
    rd_flags = acc && !pwrite && (paddr == OFS_IRQ);
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    tmr_start = 1'b0;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.line_s1 = fault_line_in;
    s_next.line_s2 = s_reg.line_s1;
    s_next.on_prev = on_cmd;
    // Interrupt status: read clears, set wins
    s_next.irq_st = (rd_flags ? 6'h00 : s_reg.irq_st) | ev;
    s_next.irq = |(s_next.irq_st & s_reg.mask);
    // APB access, one wait state
    if (acc) begin
      s_next.pready = 1'b1;
      s_next.prdata = '0;
      case (paddr)
        OFS_CTRL: begin
          if (pwrite) begin
            s_next.latching = pwdata[0];
            s_next.track_en = pwdata[1];
          end
          s_next.prdata = {30'h0, s_reg.track_en, s_reg.latching};
        end
        OFS_PROP: begin
          if (pwrite) s_next.prop_en = pwdata[0];
          s_next.prdata = {31'h0, s_reg.prop_en};
        end
        OFS_OVPCT: begin
          if (pwrite) s_next.ov_pct = pct_clamp(pwdata[7:0]);
          s_next.prdata = {24'h0, s_reg.ov_pct};
        end
        OFS_DELAY: begin
          if (pwrite) s_next.delay = pwdata[15:0];
          s_next.prdata = {16'h0, s_reg.delay};
        end
        OFS_FLAGS: begin
          if (pwrite) s_next.flags = s_reg.flags | pwdata[5:0];
          s_next.prdata = {26'h0, s_reg.flags};
        end
        OFS_IRQ: s_next.prdata = {26'h0, s_reg.irq_st};
        OFS_MASK: begin
          if (pwrite) s_next.mask = pwdata[5:0];
          s_next.prdata = {26'h0, s_reg.mask};
        end
        OFS_STATE: s_next.prdata = {29'h0, s_reg.st};
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // Flags drop to 0 on a trip; hardware wins over software
    s_next.flags = s_next.flags & ~ev;
    // Power sequencing
    case (s_reg.st)
      PFP_OFF: begin
        s_next.drive = '0;
        s_next.ls_hold = 1'b0;
        if (on_cmd && !s_reg.on_prev) s_next.retry_ok = 1'b1;
        if (on_cmd && s_reg.retry_ok && (&s_next.flags)
            && !meas.ot_trip) begin
          s_next.st = PFP_RAMP;
          s_next.en = 1'b1;
          // Low side is only held on by an error shutdown
          s_next.drive = '{hs_en: 1'b1, ls_en: 1'b0,
                           ramp_up: 1'b1, ramp_down: 1'b0};
        end
      end
      PFP_RAMP, PFP_ON: begin
        if (s_reg.st == PFP_RAMP && meas.vout_mv >= meas.setpoint_mv) begin
          s_next.st = PFP_ON;
          s_next.drive.ramp_up = 1'b0;
        end
        if (!on_cmd) begin
          s_next.st = PFP_DELAY;
          s_next.dly_cnt = s_reg.delay;
        end
        if (ev[F_OV] || (ev[F_EXT] && s_reg.err_off)) begin
          // Fast off; detector turns its low side on
          s_next.st = PFP_WAIT;
          s_next.drive = '{hs_en: 1'b0, ls_en: ev[F_OV],
                           ramp_up: 1'b0, ramp_down: 1'b0};
          s_next.ls_hold = ev[F_OV];
          s_next.own_fault = ev[F_OV] && s_reg.prop_en;
          s_next.err_off = 1'b1;
          s_next.retry_ok = !s_reg.latching;
          tmr_start = 1'b1;
        end else if (ev[F_OC] || ev[F_TR]) begin
          s_next.st = PFP_WAIT;
          s_next.drive = '0;
          s_next.own_fault = s_reg.prop_en;
          s_next.retry_ok = !s_reg.latching;
          tmr_start = 1'b1;
        end else if (ev[F_OT] || ev[F_UV] || ev[F_EXT]) begin
          s_next.st = PFP_DELAY;
          s_next.dly_cnt = s_reg.delay;
          s_next.own_fault = !ev[F_EXT] && s_reg.prop_en;
          s_next.retry_ok = !s_reg.latching;
        end
      end
      PFP_DELAY: begin
        if (s_reg.dly_cnt == 16'h0) begin
          s_next.st = PFP_FALL;
          s_next.drive.ramp_down = 1'b1;
          s_next.drive.ramp_up = 1'b0;
        end else begin
          s_next.dly_cnt = s_reg.dly_cnt - 16'h1;
        end
      end
      PFP_FALL: begin
        if (meas.at_zero) begin
          s_next.st = PFP_WAIT;
          s_next.drive = '0;
          tmr_start = 1'b1;
        end
      end
      PFP_WAIT: begin
        s_next.en = 1'b0;
        if (tmr_done) begin
          s_next.st = PFP_OFF;
          s_next.own_fault = 1'b0;
          s_next.err_off = 1'b0;
          s_next.drive.ls_en = 1'b0;
          if (!s_reg.latching) s_next.flags = FLAGS_RST;
        end
      end
      default: s_next.st = PFP_OFF;
    endcase
    s_next.line_oe = s_next.own_fault;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ov_pct <= OVPCT_RST;
      s_reg.delay <= DELAY_RST;
      s_reg.flags <= FLAGS_RST;
      s_reg.line_s1 <= 1'b1;
      s_reg.line_s2 <= 1'b1;
      s_reg.retry_ok <= 1'b1;
      s_reg.on_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  pfp_retry_timer #(.CYCLES(RETRY)) u_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (tmr_start),
    .done     (tmr_done)
  );

  // Outputs straight from the state register, fault_line_out tied low
  assign prdata         = s_reg.prdata;
  assign pready         = s_reg.pready;
  assign pslverr        = s_reg.pslverr;
  assign drive          = s_reg.drive;
  assign irq            = s_reg.irq;
  assign fault_line_oe  = s_reg.line_oe;
  assign fault_line_out = 1'b0;

  property p_ov_fast;
    @(posedge core_clk) disable iff (rst)
    (s_reg.st inside {PFP_RAMP, PFP_ON}) && ov_hit |=>
      !drive.hs_en && drive.ls_en && !s_reg.flags[F_OV];
  endproperty
  a_ov_fast: assert property (p_ov_fast) else $error("ov response");

  property p_oc_off;
    @(posedge core_clk) disable iff (rst)
    (s_reg.st inside {PFP_RAMP, PFP_ON}) && oc_hit && !ov_hit |=>
      !drive.hs_en && !drive.ls_en && s_reg.st == PFP_WAIT;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("oc response");

  property p_arm;
    @(posedge core_clk) disable iff (rst)
    meas.vout_mv <= meas.prebias_mv |-> !ov_hit && !oc_hit;
  endproperty
  a_arm: assert property (p_arm) else $error("armed below prebias");

  property p_thr;
    @(posedge core_clk) disable iff (rst)
    ov_thr >= OV_FLOOR_MV && s_reg.ov_pct >= OV_PCT_MIN &&
    s_reg.ov_pct <= OV_PCT_MAX;
  endproperty
  a_thr: assert property (p_thr) else $error("ov threshold range");

  property p_line;
    @(posedge core_clk) disable iff (rst)
    fault_line_oe |-> s_reg.prop_en || $past(s_reg.prop_en, 2);
  endproperty
  a_line: assert property (p_line) else $error("line without prop");

  property p_ext;
    @(posedge core_clk) disable iff (rst)
    s_reg.st == PFP_ON && ev[F_EXT] && !s_reg.err_off &&
    !(|ev[F_TR:F_OV]) |=> s_reg.st == PFP_DELAY;
  endproperty
  a_ext: assert property (p_ext) else $error("peer fault ignored");

  sequence s_delay_zero;
    s_reg.st == PFP_DELAY && s_reg.dly_cnt == 16'h0;
  endsequence
  property p_fall;
    @(posedge core_clk) disable iff (rst)
    s_delay_zero |=> s_reg.st == PFP_FALL && drive.ramp_down;
  endproperty
  a_fall: assert property (p_fall) else $error("no ramp down");

  property p_ot;
    @(posedge core_clk) disable iff (rst)
    meas.ot_trip |=> !s_reg.flags[F_OT];
  endproperty
  a_ot: assert property (p_ot) else $error("ot flag");

  property p_wait;
    @(posedge core_clk) disable iff (rst)
    s_reg.st == PFP_FALL && meas.at_zero |=> s_reg.st == PFP_WAIT;
  endproperty
  a_wait: assert property (p_wait) else $error("hiccup start");
endmodule // pfp_core
`default_nettype wire

// ==== rtl/pfp_pkg.sv ====
// Constants and carrier types for the power fault propagation block.
// Assumes one 100 MHz clock and an APB master for software access.
// Summary of operation
// - Arm overvoltage detection only while output is above pre-bias level.
// - Overvoltage: raise error, turn off, clear its status bit, high off, low on.
// - Overvoltage threshold 110 to 130 percent of setpoint, never below 1.0V.
// - A configuration bit written by software enables propagation in the group.
// - With propagation on, a detected fault pulls the group fault line low.
// - A fault line held low by another member starts our own turn-off.
// - A received fault leads to a regular turn-off.
// - The detecting converter turns off regular or fast by its own fault type.
// - Received error turns off fast (code: regular, err_off is never set in ramp or on); detector turns off fast with low side on.
// - Non-latching: retry start every 130ms, counted from output reaching zero (code: fast turn-offs count from the fault).
// - Regular turn-off waits the programmed delay then ramps down at set slew.
// - Overcurrent active above pre-bias, fast off with low side off, always on.
// - Overtemperature always active, regular off, low side off, always on.
// - Latching: stay off; restart after 130ms only on clear, on-cycle or power cycle (code: needs both a flag write and an on-cycle, or a reset).
// - Tracking check, disableable, faults when ramp error exceeds 250mV.
`default_nettype none
package pfp_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned RETRY_MS     = 130;
  localparam int unsigned RETRY_CYCLES = RETRY_MS * (CLK_HZ / 1000);
  // Millivolt and percent figures used by the comparators
  localparam logic [15:0] OV_FLOOR_MV  = 16'd1000;
  localparam logic [15:0] TRACK_MV     = 16'd250;
  localparam logic [7:0]  OV_PCT_MIN   = 8'd110;
  localparam logic [7:0]  OV_PCT_MAX   = 8'd130;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PROP   = 8'h04;
  localparam logic [7:0] OFS_OVPCT  = 8'h08;
  localparam logic [7:0] OFS_DELAY  = 8'h0c;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_IRQ    = 8'h14;
  localparam logic [7:0] OFS_MASK   = 8'h18;
  localparam logic [7:0] OFS_STATE  = 8'h1c;
  // Reset values
  localparam logic [7:0]  OVPCT_RST  = 8'd120;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [5:0]  FLAGS_RST  = 6'h3f;
  // Flag bit positions (flag reads 0 while tripped)
  localparam int unsigned F_OV = 0;
  localparam int unsigned F_OC = 1;
  localparam int unsigned F_UV = 2;
  localparam int unsigned F_OT = 3;
  localparam int unsigned F_TR = 4;
  localparam int unsigned F_EXT = 5;

  typedef enum logic [2:0] {
    PFP_OFF   = 3'b000,
    PFP_RAMP  = 3'b001,
    PFP_ON    = 3'b010,
    PFP_DELAY = 3'b011,
    PFP_FALL  = 3'b100,
    PFP_WAIT  = 3'b101
  } pfp_state_t;

  // Analog front-end measurements in millivolts
  typedef struct packed {
    logic [15:0] vout_mv;
    logic [15:0] prebias_mv;
    logic [15:0] setpoint_mv;
    logic [15:0] ramp_ref_mv;
    logic        oc_trip;
    logic        ot_trip;
    logic        uv_trip;
    logic        at_zero;
  } pfp_meas_t;

  // Power stage commands
  typedef struct packed {
    logic hs_en;
    logic ls_en;
    logic ramp_up;
    logic ramp_down;
  } pfp_drive_t;
endpackage
`default_nettype wire

// ==== rtl/pfp_retry_timer.sv ====
// Down counter timing the restart interval after the output reaches zero or after a fast turn-off.
// Assumes load and count come from logic on the same clock.
`default_nettype none
module pfp_retry_timer
  import pfp_pkg::*;
#(
  parameter int unsigned CYCLES = RETRY_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      done
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } pfp_tmr_t;
  pfp_tmr_t s_reg, s_next;

  // Count down once started, pulse done at the end
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start) begin
      s_next.cnt = CYCLES;
    end else if (s_reg.cnt == 32'h1) begin
      s_next.cnt = 32'h0;
      s_next.done = 1'b1;
    end else if (s_reg.cnt != 32'h0) begin
      s_next.cnt = s_reg.cnt - 32'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done = s_reg.done;
endmodule // pfp_retry_timer
`default_nettype wire

// ==== sim/pfp_core_tb.sv ====
// Self-checking bench for pfp_core: APB register access and fault paths.
// Assumes pfp_fault_line_model closes the open-drain group line.
`default_nettype none
module pfp_core_tb;
  import pfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RETRY_SIM = 50;
  localparam int unsigned LIMIT     = 20000;
  typedef struct packed {
    logic [31:0] data;
    logic        err;
    logic        chk;
  } pfp_exp_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, on_cmd = 1'b0, line, other_line, irq;
  logic fl_out, fl_oe, peer_pull = 1'b0;
  pfp_meas_t meas;
  pfp_drive_t drive;
  pfp_exp_t exp_q[$];
  pfp_exp_t e;
  logic [31:0] lfsr = 32'h778a5591;
  int err_total = 0, cmp_count = 0, cyc = 0;

  pfp_core #(.RETRY(RETRY_SIM)) i_pfp_core (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .on_cmd(on_cmd),
    .fault_line_in(line), .fault_line_out(fl_out),
    .fault_line_oe(fl_oe), .drive(drive), .irq(irq));
  pfp_fault_line_model i_pfp_fault_line_model (
    .core_clk(core_clk), .dev_out(fl_out), .dev_oe(fl_oe),
    .peer_pull(peer_pull), .mgr_prop_en(1'b1), .line(line),
    .other_line(other_line));

  // Clock of 10 ns period
  always #5 core_clk = !core_clk;

  // Compare tasks and closing report
  task automatic check_reg(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic check_pin(input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Stimulus helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input pfp_exp_t x);
    int n;
    n = 0;
    exp_q.push_back(x);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{32'h0, 1'b0, 1'b0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, '{d, 1'b0, 1'b1});
  endtask
  // Set output levels, let them settle, check high and low side
  task automatic step(input logic [15:0] v, input logic [15:0] sp,
                      input logic [15:0] pb, input logic [1:0] hl);
    meas.vout_mv <= v;
    meas.setpoint_mv <= sp;
    meas.prebias_mv <= pb;
    tick(5);
    check_pin({2'b00, hl}, {2'b00, drive.hs_en, drive.ls_en});
  endtask
  // Clear causes, wait out the hiccup, restore flags, turn back on
  task automatic recover();
    meas.oc_trip <= 1'b0;
    meas.ot_trip <= 1'b0;
    meas.vout_mv <= 16'd0;
    meas.at_zero <= 1'b1;
    peer_pull <= 1'b0;
    tick(RETRY_SIM + 20);
    wr(OFS_FLAGS, 32'h3f);
    rd(OFS_FLAGS, 32'h3f);
    meas.at_zero <= 1'b0;
    meas.setpoint_mv <= 16'd1000;
    meas.vout_mv <= 16'd1000;
    tick(20);
  endtask

  // Result watcher: each APB answer is matched to the oldest note
  always @(posedge core_clk) begin
    cyc++;
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_reg(32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        check_reg({31'h0, e.err}, {31'h0, pslverr});
        if (e.chk) check_reg(e.data, prdata);
      end
    end
    if (cyc == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    meas = '0;
    meas.setpoint_mv = 16'd1000;
    tick(6);
    rst <= 1'b0;
    rd(OFS_OVPCT, {24'h0, OVPCT_RST});
    rd(OFS_FLAGS, {26'h0, FLAGS_RST});
    rd(OFS_DELAY, {16'h0, DELAY_RST});
    apb(1'b0, 8'h20, 32'h0, '{32'h0, 1'b1, 1'b0});
    apb(1'b1, 8'h24, 32'h5, '{32'h0, 1'b1, 1'b0});
    lfsr = lfsr_next(lfsr);
    wr(OFS_DELAY, {24'h0, lfsr[7:0]});
    rd(OFS_DELAY, {24'h0, lfsr[7:0]});
    wr(OFS_DELAY, 32'h0);
    wr(OFS_OVPCT, 32'hc8);
    rd(OFS_OVPCT, {24'h0, OV_PCT_MAX});
    wr(OFS_OVPCT, 32'h05);
    rd(OFS_OVPCT, {24'h0, OV_PCT_MIN});
    wr(OFS_OVPCT, 32'h78);
    wr(OFS_PROP, 32'h1);
    wr(OFS_MASK, 32'h3f);
    on_cmd <= 1'b1;
    meas.vout_mv <= 16'd1000;
    tick(20);
    // Overvoltage thresholds: percent, pre-bias gate, 1.0V floor
    step(16'd1190, 16'd1000, 16'd0, 2'b10);
    step(16'd1300, 16'd1000, 16'd1400, 2'b10);
    step(16'd900, 16'd500, 16'd0, 2'b10);
    step(16'd1010, 16'd500, 16'd0, 2'b01);
    check_pin(4'h1, {3'h0, fl_oe});
    check_pin(4'h1, {3'h0, irq});
    rd(OFS_FLAGS, 32'h3e);
    meas.vout_mv <= 16'd0;
    rd(OFS_IRQ, 32'h1);
    tick(2);
    check_pin(4'h0, {3'h0, irq});
    recover();
    check_pin(4'h0, {3'h0, fl_oe});
    // Peer pulls the line: own turn-off without pulling back
    peer_pull <= 1'b1;
    tick(8);
    check_pin(4'h1, {3'h0, drive.ramp_down});
    check_pin(4'h0, {3'h0, fl_oe});
    check_pin(4'h0, {3'h0, other_line});
    rd(OFS_FLAGS, 32'h1f);
    recover();
    // Overcurrent: fast turn-off, both switches off, line pulled
    meas.oc_trip <= 1'b1;
    tick(5);
    check_pin(4'h0, {2'b00, drive.hs_en, drive.ls_en});
    check_pin(4'h1, {3'h0, fl_oe});
    rd(OFS_FLAGS, 32'h3d);
    recover();
    // Overtemperature with propagation off: low side off, no pull
    wr(OFS_PROP, 32'h0);
    meas.ot_trip <= 1'b1;
    tick(5);
    check_pin(4'h0, {3'h0, drive.ls_en});
    check_pin(4'h0, {3'h0, fl_oe});
    rd(OFS_FLAGS, 32'h37);
    tick(5);
    tally_and_finish();
  end
endmodule // pfp_core_tb
`default_nettype wire

// ==== sim/pfp_fault_line_model.sv ====
// Peer converters and power manager sharing the group fault line.
// Assumes peer pull requests arrive on core_clk rising edges.
`default_nettype none
module pfp_fault_line_model (
  // Clock
  input  wire logic core_clk,
  // Device side of the open-drain pin
  input  wire logic dev_out,
  input  wire logic dev_oe,
  // Peer and manager controls
  input  wire logic peer_pull,
  input  wire logic mgr_prop_en,
  // Wire levels
  output logic      line,
  output logic      other_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic peer_oe;
  // Another group member pulls on a clock edge
  always @(posedge core_clk) begin
    peer_oe <= peer_pull;
  end
  // Wired-AND with pull-up: high only while nobody pulls
  assign line = !((dev_oe && !dev_out) || peer_oe);
  // Manager pulls another group's line low when this one falls
  assign other_line = !(mgr_prop_en && !line);
endmodule // pfp_fault_line_model
`default_nettype wire
